// ==== shared/fault_cfg_pkg.sv ====
package fault_cfg_pkg;

	localparam logic [11:0] addr_fault_detect_config = 12'h006;
	localparam logic [11:0] addr_supply_fault_irq_enables = 12'h008;
	localparam logic [11:0] addr_irq_status = 12'h00c;
	localparam logic [11:0] addr_irq_mask = 12'h010;
	localparam logic [11:0] addr_fault_raw = 12'h014;

	localparam logic [15:0] fault_detect_config_rst = 16'h0100;
	localparam logic [15:0] supply_fault_irq_enables_rst = 16'h2aaa;
	localparam logic [15:0] fault_detect_config_rw_mask = 16'h01ff;
	localparam int ground_short_detect_enable_pos = 8;
	localparam int string_disable_lsb = 0;
	localparam int num_strings = 4;

	localparam int num_supply = 7;
	localparam logic [6:0] irq_enable_rst = 7'h7f;
	localparam logic [6:0] irq_mask_rst = 7'h00;

	// Enable field low bit positions, index order matches supply_faults_t.
	localparam int missing_sync_pos = 12;
	localparam int pump_fault_pos = 10;
	localparam int pump_capacitor_missing_pos = 8;
	localparam int input_overcurrent_pos = 6;
	localparam int core_supply_undervoltage_pos = 4;
	localparam int input_overvoltage_pos = 2;
	localparam int input_undervoltage_pos = 0;

	localparam logic [1:0] field_read_disabled = 2'h0;
	localparam logic [1:0] field_read_enabled = 2'h2;
	localparam logic [1:0] field_write_disable = 2'h1;
	localparam logic [1:0] field_write_enable = 2'h3;

	typedef struct packed {
		logic missing_sync;
		logic pump_fault;
		logic pump_capacitor_missing;
		logic input_overcurrent;
		logic core_supply_undervoltage;
		logic input_overvoltage;
		logic input_undervoltage;
	} supply_faults_t;

	typedef struct packed {
		logic ground_short_detect_enable;
		logic [3:0] string_internal_short_disable;
	} led_detect_ctrl_t;

	function automatic int field_pos(input int idx);
		case (idx)
			6: field_pos = missing_sync_pos;
			5: field_pos = pump_fault_pos;
			4: field_pos = pump_capacitor_missing_pos;
			3: field_pos = input_overcurrent_pos;
			2: field_pos = core_supply_undervoltage_pos;
			1: field_pos = input_overvoltage_pos;
			default: field_pos = input_undervoltage_pos;
		endcase
	endfunction : field_pos

endpackage : fault_cfg_pkg

// ==== logic/irq_enable_field.sv ====
`timescale 1ns/1ps
module irq_enable_field
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic wr,
	input wire logic [1:0] wdata,
	output logic enabled
);
	import fault_cfg_pkg::*;

	logic en_r;
	logic en_nxt;

	always_comb
	begin
		en_nxt = en_r;
		// Lower bit acts as strobe, so 0h and 2h leave the state alone.
		if (wr && wdata == field_write_disable)
			en_nxt = 1'b0;
		else if (wr && wdata == field_write_enable)
			en_nxt = 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			en_r <= 1'b1;
		else
			en_r <= en_nxt;
	end

	assign enabled = en_r;
endmodule : irq_enable_field

// ==== logic/fault_config_irq_enable_regs.sv ====
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
// Notes on behaviour
// - Ground-short detection runs in soft-start and normal stage only while bit 8 is 1, which it is after reset.
// - Bits 3..0 each suppress the internal-short fault of strings four..one when 1, and reset to 0.
// - A supply interrupt enable field reads 0h when disabled and 2h when enabled.
// - Writing 1h to a supply enable field disables it and writing 3h enables it.
// - The missing boost sync enable sits in bits 13..12 and resets enabled.
// - The charge pump fault enable sits in bits 11..10 and resets enabled.
// - The missing pump capacitor enable sits in bits 9..8 and resets enabled.
// - Input over-current, over-voltage and under-voltage enables sit in bits 7..6, 3..2 and 1..0, all reset enabled.
// - The core supply under-voltage enable sits in bits 5..4 and resets enabled.
// - Bits 15..14 of the supply enable register are reserved and read zero.
module fault_config_irq_enable_regs
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire fault_cfg_pkg::supply_faults_t supply_fault_in,
	input wire logic [1:0] led_stage,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output fault_cfg_pkg::led_detect_ctrl_t led_detect_ctrl,
	output logic ground_short_detect_active,
	output logic irq
);
	import fault_cfg_pkg::*;

	// led_stage: 0 idle, 1 boost soft-start, 2 normal, 3 other.
	typedef enum logic [1:0] {
		st_idle = 2'b00,
		st_soft_start = 2'b01,
		st_normal = 2'b10,
		st_other = 2'b11
	} led_stage_t;

	logic [15:0] cfg_r;
	logic [15:0] cfg_nxt;
	logic [6:0] status_r;
	logic [6:0] status_nxt;
	logic [6:0] mask_r;
	logic [6:0] mask_nxt;
	logic [31:0] prdata_nxt;
	logic pready_r;
	logic pready_nxt;
	logic pslverr_nxt;
	logic irq_nxt;
	logic gsd_nxt;
	led_detect_ctrl_t ctrl_nxt;
	logic [6:0] field_en;
	logic [6:0] field_wr;
	logic [15:0] supply_rd;
	logic setup;
	logic wr_cfg;
	logic wr_sup;
	logic wr_mask;
	logic rd_status;
	logic mapped;
	led_stage_t stage;

	assign stage = led_stage_t'(led_stage);
	// Access is taken in the setup cycle and answered one cycle later with pready.
	assign setup = psel && !penable;
	assign mapped = paddr == addr_fault_detect_config || paddr == addr_supply_fault_irq_enables
		|| paddr == addr_irq_status || paddr == addr_irq_mask || paddr == addr_fault_raw;
	assign wr_cfg = setup && pwrite && paddr == addr_fault_detect_config;
	assign wr_sup = setup && pwrite && paddr == addr_supply_fault_irq_enables;
	assign wr_mask = setup && pwrite && paddr == addr_irq_mask;
	assign rd_status = setup && !pwrite && paddr == addr_irq_status;

	genvar gi;
	generate
		for (gi = 0; gi < num_supply; gi++)
		begin : g_field
			localparam int pos = field_pos(gi);
			// A field is written only when its byte lane is strobed.
			assign field_wr[gi] = wr_sup && pstrb[pos / 8];
			irq_enable_field u_field
			(
				.pclk(pclk),
				.presetn(presetn),
				.wr(field_wr[gi]),
				.wdata(pwdata[pos +: 2]),
				.enabled(field_en[gi])
			);
		end
	endgenerate

	always_comb
	begin
		supply_rd = 16'h0000;
		for (int i = 0; i < num_supply; i++)
			supply_rd[field_pos(i) +: 2] = field_en[i] ? field_read_enabled : field_read_disabled;
	end

	always_comb
	begin
		cfg_nxt = cfg_r;
		if (wr_cfg)
		begin
			// Reserved bits 7..4 are kept as written; software should leave them zero.
			if (pstrb[0])
				cfg_nxt[7:0] = pwdata[7:0];
			if (pstrb[1])
				cfg_nxt[15:8] = pwdata[15:8] & fault_detect_config_rw_mask[15:8];
		end
		mask_nxt = mask_r;
		if (wr_mask && pstrb[0])
			mask_nxt = pwdata[6:0];
		// A fault arriving during the clearing read wins over the clear.
		status_nxt = (rd_status ? 7'h00 : status_r) | (supply_fault_in & field_en);
		irq_nxt = |(status_nxt & ~mask_nxt);
		ctrl_nxt.ground_short_detect_enable = cfg_nxt[ground_short_detect_enable_pos];
		ctrl_nxt.string_internal_short_disable = cfg_nxt[string_disable_lsb +: num_strings];
		gsd_nxt = ctrl_nxt.ground_short_detect_enable && (stage == st_soft_start || stage == st_normal);
		pready_nxt = setup;
		pslverr_nxt = setup && !mapped;
		prdata_nxt = 32'h0000_0000;
		if (setup && !pwrite)
		begin
			unique case (paddr)
				addr_fault_detect_config: prdata_nxt = {16'h0000, cfg_r};
				addr_supply_fault_irq_enables: prdata_nxt = {16'h0000, supply_rd};
				addr_irq_status: prdata_nxt = {25'h0000000, status_r};
				addr_irq_mask: prdata_nxt = {25'h0000000, mask_r};
				addr_fault_raw: prdata_nxt = {25'h0000000, supply_fault_in};
				default: prdata_nxt = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cfg_r <= fault_detect_config_rst;
			status_r <= 7'h00;
			mask_r <= irq_mask_rst;
			prdata <= 32'h0000_0000;
			pready_r <= 1'b0;
			pslverr <= 1'b0;
			irq <= 1'b0;
			led_detect_ctrl <= '{ground_short_detect_enable: 1'b1, string_internal_short_disable: 4'h0};
			ground_short_detect_active <= 1'b0;
		end
		else
		begin
			cfg_r <= cfg_nxt;
			status_r <= status_nxt;
			mask_r <= mask_nxt;
			prdata <= prdata_nxt;
			pready_r <= pready_nxt;
			pslverr <= pslverr_nxt;
			irq <= irq_nxt;
			led_detect_ctrl <= ctrl_nxt;
			ground_short_detect_active <= gsd_nxt;
		end
	end

	assign pready = pready_r;
endmodule : fault_config_irq_enable_regs

// ==== tb/regs_checker.sv ====
`timescale 1ns/1ps
module regs_checker
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire fault_cfg_pkg::supply_faults_t supply_fault_in,
	input wire logic [1:0] led_stage,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire fault_cfg_pkg::led_detect_ctrl_t led_detect_ctrl,
	input wire logic ground_short_detect_active,
	input wire logic irq
);
	import fault_cfg_pkg::*;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence rd_s(logic [11:0] a);
		pready && !pwrite && paddr == a;
	endsequence
	a_ready_one: assert property (setup_s |=> pready) else $error("pready late");
	a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
	a_idle_zero: assert property (!pready |-> prdata == 32'h0) else $error("prdata not idle");
	a_enc_read: assert property (rd_s(addr_supply_fault_irq_enables) |-> (prdata & 32'hffffd555) == 32'h0)
		else $error("bad enable read");
	a_cfg_read: assert property (rd_s(addr_fault_detect_config) |-> prdata[31:9] == 23'h0)
		else $error("bad config read");
	a_ctrl_follow: assert property (setup_s ##0 (pwrite && paddr == addr_fault_detect_config && pstrb[1:0] == 2'h3)
		|=> led_detect_ctrl == {pwdata[8], pwdata[3:0]}) else $error("ctrl not updated");
	a_gnd_stage: assert property (ground_short_detect_active |-> $past(led_stage) inside {2'h1, 2'h2})
		else $error("detect outside stage");
	a_irq_cause: assert property ($rose(irq) |-> $past(supply_fault_in != 7'h0
		|| (psel && !penable && pwrite && paddr == addr_irq_mask))) else $error("irq no fault");
endmodule : regs_checker
bind fault_config_irq_enable_regs regs_checker u_chk (.*);

// ==== tb/tb.sv ====
`timescale 1ns/1ps
module tb;
	import fault_cfg_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'hf;
	supply_faults_t supply_fault_in = '0;
	logic [1:0] led_stage = 2'h0;
	logic [31:0] prdata;
	logic pready, pslverr, ground_short_detect_active, irq;
	led_detect_ctrl_t led_detect_ctrl;
	int n_errors = 0;
	int cmp_count = 0;
	int cyc = 0;
	logic [31:0] r;
	logic e;
	logic [15:0] ex;
	int pos [7] = '{0, 2, 4, 6, 8, 10, 12};
	always #5 pclk = ~pclk;
	fault_config_irq_enable_regs u_dut (.*);
	task automatic summarize();
		if (n_errors == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : summarize
	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] got);
		cmp_count++;
		if (got !== x)
		begin
			n_errors++;
			$display("MISMATCH %s exp %h got %h", nm, x, got);
		end
	endtask : chk
	// The answer is taken at the rising edge that samples pready high, and only then is the request released.
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
	task automatic rdc(input logic [11:0] a, input logic [31:0] x, input string nm);
		xfer(1'b0, a, 32'h0, 4'hf);
		chk(nm, x, r);
	endtask : rdc
	task automatic pulse(input supply_faults_t f);
		@(posedge pclk);
		supply_fault_in <= f;
		@(posedge pclk);
		supply_fault_in <= '0;
		@(negedge pclk);
	endtask : pulse
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			n_errors++;
			summarize();
		end
	end
	initial
	begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		chk("ctrl_rst", 32'h10, 32'(led_detect_ctrl));
		rdc(addr_fault_detect_config, 32'h100, "cfg_rst");
		rdc(addr_supply_fault_irq_enables, 32'h2aaa, "en_rst");
		xfer(1'b1, addr_fault_detect_config, 32'hfffffe0f, 4'hf);
		rdc(addr_fault_detect_config, 32'h00f, "cfg_wr");
		led_stage <= 2'h2;
		chk("ctrl_wr", 32'h0f, 32'(led_detect_ctrl));
		pulse('0);
		chk("gnd_off", 32'h0, 32'(ground_short_detect_active));
		xfer(1'b1, addr_fault_detect_config, 32'h100, 4'hf);
		@(negedge pclk);
		chk("gnd_on", 32'h1, 32'(ground_short_detect_active));
		ex = 16'h2aaa;
		for (int i = 0; i < 7; i++)
		begin
			xfer(1'b1, addr_supply_fault_irq_enables, 32'h1 << pos[i], 4'hf);
			ex[pos[i] + 1] = 1'b0;
			rdc(addr_supply_fault_irq_enables, {16'h0, ex}, "en_off");
		end
		xfer(1'b1, addr_supply_fault_irq_enables, 32'hffff2aaa, 4'hf);
		rdc(addr_supply_fault_irq_enables, 32'h0, "en_keep");
		pulse(7'h7f);
		chk("irq_dis", 32'h0, 32'(irq));
		rdc(addr_irq_status, 32'h0, "sts_dis");
		xfer(1'b1, addr_supply_fault_irq_enables, 32'hffffffff, 4'hf);
		rdc(addr_supply_fault_irq_enables, 32'h2aaa, "en_on");
		pulse(7'h01);
		chk("irq_on", 32'h1, 32'(irq));
		rdc(addr_irq_status, 32'h1, "sts");
		xfer(1'b1, addr_irq_mask, 32'h40, 4'hf);
		pulse(7'h40);
		chk("irq_mask", 32'h0, 32'(irq));
		xfer(1'b1, addr_irq_mask, 32'h0, 4'hf);
		@(negedge pclk);
		chk("irq_unmask", 32'h1, 32'(irq));
		rdc(addr_irq_status, 32'h40, "sts_m");
		rdc(12'h0fc, 32'h0, "bad_rd");
		chk("bad_err", 32'h1, 32'(e));
		summarize();
	end
endmodule : tb
